/* logic/hmgw_pkg.sv */
// Package for the field-bus gateway: register map, reset values, limits, timing.
// Assumes a 100 MHz clock and byte addresses on the register bus.
package hmgw_pkg;
  localparam int CLK_MHZ = 100;
  localparam int HART_TMO_MS = 50;
  localparam int HART_TMO_CYC = CLK_MHZ * 1000 * HART_TMO_MS;
  localparam int SEC_MS = 1000;
  localparam int SEC_CYC = CLK_MHZ * 1000 * SEC_MS;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SLVADDR = 12'h004;
  localparam logic [11:0] OFS_RETRY = 12'h008;
  localparam logic [11:0] OFS_ALM0 = 12'h00c;
  localparam logic [11:0] OFS_ALM1 = 12'h010;
  localparam logic [11:0] OFS_STAT = 12'h014;
  localparam logic [11:0] OFS_CHST = 12'h400;
  localparam logic [11:0] OFS_PV = 12'h800;
  // CTRL fields
  localparam int CTRL_DIS2 = 0;
  localparam int CTRL_HIFIRST = 1;
  localparam int CTRL_PAR_LO = 2;
  localparam int CTRL_BAUD_LO = 4;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [2:0] BAUD_9600 = 3'h5;
  localparam logic [2:0] BAUD_MAX = 3'h6;
  // ALM fields
  localparam int ALM_DLY_LO = 8;
  localparam int ALM_FS = 16;
  localparam logic [6:0] DLY_MAX = 7'h78;
  // Limits and defaults
  localparam logic [7:0] SLV_MIN = 8'h01;
  localparam logic [7:0] SLV_MAX = 8'hf7;
  localparam logic [7:0] SLV_RST = 8'h01;
  localparam logic [3:0] RETRY_MIN = 4'h1;
  localparam logic [3:0] RETRY_MAX = 4'h9;
  localparam logic [3:0] RETRY_RST = 4'h3;
  // Channel status bits
  localparam int ST_WIRE = 1;
  localparam int ST_ADC = 2;
  localparam int ST_CURVE = 3;
  localparam int ST_SAT = 4;
  localparam int ST_RANGE = 5;
  // MODBUS register numbers
  localparam logic [10:0] MB_PV_LAST = 11'h040;
  localparam logic [10:0] MB_ST_FIRST = 11'h3e9;
  localparam logic [10:0] MB_ST_LAST = 11'h408;
  localparam logic [10:0] MB_GW_ST = 11'h7d1;
  localparam int GW_HWFAIL = 0;
  localparam int GW_NOHART = 15;
  typedef enum logic [1:0] {HM_IDLE, HM_REQ, HM_WAIT} hmgw_poll_t;
endpackage

/* logic/hmgw_gateway.sv */
// Field-bus gateway core: polls two 16-channel modules, keeps their data,
// serves it to the serial slave engines and drives alarm relays and LEDs.
// Assumes the field modem and both serial engines sit outside, same clock.
// Summary of operation
// - Gateway alone starts every field poll
// - Poll only addresses 1 and 2
// - Sixteen channels with status per module
// - Both serial ports share one configuration
// - Failsafe relay energized while module is healthy
// - Alarm on any selected fault condition
// - Trip after condition persists programmed seconds
// - Failsafe or non-failsafe choice per alarm
// - Failsafe de-energizes, non-failsafe energizes on trip
// - Fault LED red on alarm; disabled stays green
// - Input LED red when field input lost
// - Ready LED red after internal problem
// - Slave address 1 to 247, default 1
// - Seven baud rates, default 9600 no parity
// - Even, odd or no parity
// - Start, eight data, optional parity, stop
// - Float word order selectable, low first default
// - Low first puts low half first
// - Answer serial requests within 50 ms
// - Input change reaches registers within 1 s
// - Trip within update time plus 150 ms
// - RTU framing over RS-485 on both ports
// - Retry unanswered poll 1-9 times, default 3
`timescale 1ns/1ps
module hmgw_gateway
  import hmgw_pkg::*;
#(
  parameter int TMO_CYC = HART_TMO_CYC,
  parameter int S_CYC = SEC_CYC
)(
  input wire logic clock, // 100 MHz
  input wire logic srst, // Sync reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic hartReq, // Poll pulse to field modem
  output logic [1:0] hartAddr, // Polling address
  input wire logic hartRspValid, // Response beat
  input wire logic hartRspLast, // Last beat of response
  input wire logic [3:0] hartRspChan, // Channel of beat
  input wire logic [7:0] hartRspStatus, // Channel status
  input wire logic [31:0] hartRspPv, // Channel process_value
  input wire logic hwFault, // Internal problem
  input wire logic mbRegRd, // Serial engine register read
  input wire logic [10:0] mbRegNum, // Register number
  output logic [15:0] mbRegData, // Register value
  output logic mbRegAck, // Read answer pulse
  output logic [7:0] mbSlaveAddr, // Shared slave address
  output logic [2:0] mbBaudSel, // Shared baud select
  output logic [1:0] mbParity, // Shared parity
  output logic [1:0] relayOn, // Fault relay energized
  output logic [1:0] faultLedRed, // Fault LEDs, 0 green
  output logic inputLedRed, // Input LED
  output logic readyLedRed // Ready LED
);
  logic [31:0] pvMem [0:31];
  logic [7:0] stMem [0:31];
  logic [6:0] ctrl_q;
  logic [7:0] slv_q;
  logic [3:0] retry_q;
  logic [16:0] alm_q [0:1];
  hmgw_poll_t state_q;
  logic cur_q;
  logic [3:0] fails_q;
  logic [31:0] tmo_q;
  logic [1:0] noHart_q;
  logic [1:0] trip_q;
  logic [1:0] relay_q;
  logic [1:0] faultRed_q;
  logic inRed_q;
  logic rdyRed_q;
  logic req_q;
  logic [1:0] addr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [15:0] mbData_q;
  logic mbAck_q;

  // Register bus decode
  wire setup = psel && !penable;
  wire wrEn = psel && penable && pready_q && pwrite;
  wire selCtrl = paddr == OFS_CTRL;
  wire selSlv = paddr == OFS_SLVADDR;
  wire selRetry = paddr == OFS_RETRY;
  wire selAlm0 = paddr == OFS_ALM0;
  wire selAlm1 = paddr == OFS_ALM1;
  wire selStat = paddr == OFS_STAT;
  wire selCh = paddr[11:7] == OFS_CHST[11:7] && paddr[1:0] == 2'h0;
  wire selPv = paddr[11:7] == OFS_PV[11:7] && paddr[1:0] == 2'h0;
  wire [4:0] memIdx = paddr[6:2];
  wire mapped = selCtrl | selSlv | selRetry | selAlm0 | selAlm1 | selStat | selCh | selPv;
  wire dis2 = ctrl_q[CTRL_DIS2];
  wire hiFirst = ctrl_q[CTRL_HIFIRST];
  wire [1:0] wPar = pwdata[CTRL_PAR_LO+:2];
  wire [2:0] wBaud = pwdata[CTRL_BAUD_LO+:3];
  wire ctrlOk = wPar <= PAR_ODD && wBaud <= BAUD_MAX;
  wire slvOk = pwdata[7:0] >= SLV_MIN && pwdata[7:0] <= SLV_MAX && pwdata[31:8] == 24'h0;
  wire retryOk = pwdata[3:0] >= RETRY_MIN && pwdata[3:0] <= RETRY_MAX;
  wire almOk = pwdata[ALM_DLY_LO+:7] <= DLY_MAX;
  wire [31:0] statWord = {26'h0, relay_q, noHart_q, trip_q};
  wire [31:0] rdMux =
    selCtrl ? {25'h0, ctrl_q} :
    selSlv ? {24'h0, slv_q} :
    selRetry ? {28'h0, retry_q} :
    selAlm0 ? {15'h0, alm_q[0]} :
    selAlm1 ? {15'h0, alm_q[1]} :
    selStat ? statWord :
    selCh ? {24'h0, stMem[memIdx]} :
    selPv ? pvMem[memIdx] : 32'h0;

  // Serial register map decode
  wire [10:0] pvIdx = mbRegNum - 11'h001;
  wire [10:0] stIdx = mbRegNum - MB_ST_FIRST;
  wire isPv = mbRegNum != 11'h000 && mbRegNum <= MB_PV_LAST;
  wire isSt = mbRegNum >= MB_ST_FIRST && mbRegNum <= MB_ST_LAST;
  wire [31:0] pvWord = pvMem[pvIdx[5:1]];
  wire hiHalf = pvIdx[0] ^ hiFirst;
  wire [15:0] gwStat = (16'h1 << GW_NOHART) * {15'h0, |noHart_q}
    | (16'h1 << GW_HWFAIL) * {15'h0, rdyRed_q};
  wire [15:0] mbMux =
    isPv ? (hiHalf ? pvWord[31:16] : pvWord[15:0]) :
    isSt ? {8'h0, stMem[stIdx[4:0]]} :
    mbRegNum == MB_GW_ST ? gwStat : 16'h0;

  // Poll sequencing
  wire beat = state_q == HM_WAIT && hartRspValid;
  wire done = beat && hartRspLast;
  wire timeout = state_q == HM_WAIT && !hartRspValid && tmo_q == 32'(TMO_CYC - 1);
  wire giveUp = timeout && fails_q >= retry_q;
  wire nextMod = dis2 ? 1'b0 : !cur_q;
  // Retry of a just-disabled module falls back to module 1
  wire curEff = cur_q && !dis2;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl_q <= {BAUD_9600, PAR_NONE, 2'h0};
      slv_q <= SLV_RST;
      retry_q <= RETRY_RST;
      alm_q[0] <= 17'h0;
      alm_q[1] <= 17'h0;
    end
    else if (wrEn)
    begin
      if (selCtrl && ctrlOk)
        ctrl_q <= pwdata[6:0];
      if (selSlv && slvOk)
        slv_q <= pwdata[7:0];
      if (selRetry && retryOk)
        retry_q <= pwdata[3:0];
      if (selAlm0 && almOk)
        alm_q[0] <= pwdata[16:0];
      if (selAlm1 && almOk)
        alm_q[1] <= pwdata[16:0];
    end
  end

  // Zero-wait access phase, data captured in setup
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      prdata_q <= setup && !pwrite ? rdMux : 32'h0;
      pslverr_q <= setup && !mapped;
    end
  end

  // Field poll master
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= HM_IDLE;
      cur_q <= 1'b0;
      fails_q <= 4'h0;
      tmo_q <= 32'h0;
      noHart_q <= 2'h0;
      req_q <= 1'b0;
      addr_q <= 2'h1;
    end
    else
    begin
      req_q <= 1'b0;
      unique case (state_q)
        HM_IDLE:
        begin
          fails_q <= 4'h0;
          state_q <= HM_REQ;
        end
        HM_REQ:
        begin
          req_q <= 1'b1;
          cur_q <= curEff;
          addr_q <= {curEff, !curEff};
          tmo_q <= 32'h0;
          state_q <= HM_WAIT;
        end
        HM_WAIT:
        begin
          tmo_q <= beat ? 32'h0 : tmo_q + 32'h1;
          if (done)
          begin
            noHart_q[cur_q] <= 1'b0;
            cur_q <= nextMod;
            state_q <= HM_IDLE;
          end
          else if (giveUp)
          begin
            noHart_q[cur_q] <= 1'b1;
            cur_q <= nextMod;
            state_q <= HM_IDLE;
          end
          else if (timeout)
          begin
            fails_q <= fails_q + 4'h1;
            state_q <= HM_REQ;
          end
        end
      endcase
      if (dis2)
        noHart_q[1] <= 1'b0;
    end
  end

  // Channel store
  always_ff @(posedge clock)
  begin
    if (beat)
    begin
      pvMem[{cur_q, hartRspChan}] <= hartRspPv;
      stMem[{cur_q, hartRspChan}] <= hartRspStatus;
    end
  end

  // Serial register answers, one cycle after request
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mbData_q <= 16'h0;
      mbAck_q <= 1'b0;
    end
    else
    begin
      mbAck_q <= mbRegRd;
      mbData_q <= mbRegRd ? mbMux : 16'h0;
    end
  end

  // Alarm path per module
  for (genvar m = 0; m < 2; m++)
  begin : g_alm
    logic [7:0] orSt;
    logic [31:0] sub_q;
    logic [6:0] secs_q;
    wire [5:0] sel = alm_q[m][5:0];
    wire [6:0] dly = alm_q[m][ALM_DLY_LO+:7];
    wire off = m == 1 && dis2;
    always_comb
    begin
      orSt = 8'h0;
      for (int c = 0; c < 16; c++)
        orSt = orSt | stMem[m*16+c];
    end
    wire [5:0] conds = {orSt[ST_RANGE], orSt[ST_SAT], orSt[ST_CURVE], orSt[ST_ADC],
      orSt[ST_WIRE], noHart_q[m]};
    wire cond = |(conds & sel) && !off;
    always_ff @(posedge clock)
    begin
      if (srst || !cond)
      begin
        sub_q <= 32'h0;
        secs_q <= 7'h0;
        trip_q[m] <= 1'b0;
      end
      else if (secs_q >= dly)
        trip_q[m] <= 1'b1;
      else if (sub_q == 32'(S_CYC - 1))
      begin
        sub_q <= 32'h0;
        secs_q <= secs_q + 7'h1;
      end
      else
        sub_q <= sub_q + 32'h1;
    end
    always_ff @(posedge clock)
    begin
      if (srst)
      begin
        relay_q[m] <= 1'b0;
        faultRed_q[m] <= 1'b0;
      end
      else
      begin
        relay_q[m] <= alm_q[m][ALM_FS] ^ trip_q[m];
        faultRed_q[m] <= trip_q[m] && !off;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      inRed_q <= 1'b0;
      rdyRed_q <= 1'b0;
    end
    else
    begin
      inRed_q <= |noHart_q;
      rdyRed_q <= rdyRed_q | hwFault;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign hartReq = req_q;
  assign hartAddr = addr_q;
  assign mbRegData = mbData_q;
  assign mbRegAck = mbAck_q;
  assign mbSlaveAddr = slv_q;
  assign mbBaudSel = ctrl_q[CTRL_BAUD_LO+:3];
  assign mbParity = ctrl_q[CTRL_PAR_LO+:2];
  assign relayOn = relay_q;
  assign faultLedRed = faultRed_q;
  assign inputLedRed = inRed_q;
  assign readyLedRed = rdyRed_q;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    pready_q && psel && penable;
  endsequence
  property p_apb;
    @(posedge clock) disable iff (srst) s_setup |=> s_access;
  endproperty
  a_apb: assert property (p_apb) else $error("no ready in access");
  property p_addr;
    @(posedge clock) disable iff (srst) req_q |-> addr_q == 2'h1 || addr_q == 2'h2;
  endproperty
  a_addr: assert property (p_addr) else $error("bad poll address");
  property p_dis2;
    @(posedge clock) disable iff (srst) dis2 && $stable(dis2) && req_q |-> addr_q == 2'h1;
  endproperty
  a_dis2: assert property (p_dis2) else $error("disabled module polled");
  property p_slv;
    @(posedge clock) disable iff (srst) 1'b1 |-> slv_q >= SLV_MIN && slv_q <= SLV_MAX;
  endproperty
  a_slv: assert property (p_slv) else $error("slave address out of range");
  property p_relay;
    @(posedge clock) disable iff (srst)
      ##1 relay_q[0] == ($past(alm_q[0][ALM_FS]) ^ $past(trip_q[0]));
  endproperty
  a_relay: assert property (p_relay) else $error("relay action wrong");
  property p_led2;
    @(posedge clock) disable iff (srst) dis2 [*2] |-> !faultRed_q[1];
  endproperty
  a_led2: assert property (p_led2) else $error("disabled fault LED red");
  property p_noDly;
    @(posedge clock) disable iff (srst)
      g_alm[1].cond && g_alm[1].dly == 7'h0 ##1 g_alm[1].cond |-> trip_q[1];
  endproperty
  a_noDly: assert property (p_noDly) else $error("zero delay did not trip");
  property p_mbAck;
    @(posedge clock) disable iff (srst) mbRegRd |=> mbAck_q ##1 !mbAck_q || $past(mbRegRd);
  endproperty
  a_mbAck: assert property (p_mbAck) else $error("serial read not answered");
  property p_fails;
    @(posedge clock) disable iff (srst) 1'b1 |-> fails_q <= RETRY_MAX;
  endproperty
  a_fails: assert property (p_fails) else $error("retry count overrun");
  property p_ok;
    @(posedge clock) disable iff (srst) done |=> !noHart_q[$past(cur_q)];
  endproperty
  a_ok: assert property (p_ok) else $error("answered module marked silent");
endmodule

/* testbench/hmgw_field_model.sv */
// Field-side stand-in: answers each poll of an unmuted module with sixteen channel beats.
// Assumes the gateway's poll pulse and address on the shared clock.
`timescale 1ns/1ps
module hmgw_field_model
(
  input wire logic clock, // Shared clock
  input wire logic srst, // Sync reset
  input wire logic hartReq, // Poll pulse
  input wire logic [1:0] hartAddr, // Polled address
  input wire logic [1:0] mute, // Module stays silent
  input wire logic [15:0] chStatus, // Status byte per module
  output logic hartRspValid, // Beat strobe
  output logic hartRspLast, // Last beat
  output logic [3:0] hartRspChan, // Beat channel
  output logic [7:0] hartRspStatus, // Beat status
  output logic [31:0] hartRspPv // Beat value
);
  logic busy_q;
  logic [4:0] cnt_q;
  logic [1:0] addr_q;
  logic [7:0] stW;
  logic [31:0] pvW;
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
      addr_q <= 2'h1;
    end
    else if (hartReq && !mute[hartAddr - 2'h1])
    begin
      busy_q <= 1'b1;
      cnt_q <= 5'h00;
      addr_q <= hartAddr;
    end
    else if (busy_q)
    begin
      cnt_q <= cnt_q + 5'h01;
      busy_q <= (cnt_q != 5'h1f);
    end
  end
  // One idle cycle between beats, one beat per channel
  assign hartRspValid = busy_q & cnt_q[0];
  assign hartRspChan = cnt_q[4:1];
  assign hartRspLast = hartRspValid & (cnt_q[4:1] == 4'hf);
  assign stW = (addr_q == 2'h2) ? chStatus[15:8] : chStatus[7:0];
  assign pvW = {8'h5a, 4'h0, cnt_q[4:1], 14'h0000, addr_q};
  // Idle lines show the inverse so stale data never passes
  assign hartRspStatus = hartRspValid ? stW : ~stW;
  assign hartRspPv = hartRspValid ? pvW : ~pvW;
endmodule

/* testbench/hmgw_gateway_tb.sv */
// Testbench for the gateway core: APB master, serial reads, field model.
// Assumes small timeout and second counts set through the parameters.
`timescale 1ns/1ps
module hmgw_gateway_tb;
  import hmgw_pkg::*;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, hwFault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, hPv;
  logic hartReq, hVal, hLast, mbRegRd, mbRegAck, inputLedRed, readyLedRed, err;
  logic [1:0] hartAddr, mbParity, relayOn, faultLedRed, mute;
  logic [3:0] hChan;
  logic [7:0] hSt, mbSlaveAddr;
  logic [15:0] chStatus, mbRegData, d;
  logic [10:0] mbRegNum;
  logic [2:0] mbBaudSel;
  int n_errors = 0;
  int compares = 0;
  hmgw_gateway #(.TMO_CYC(20), .S_CYC(10)) dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hartReq(hartReq), .hartAddr(hartAddr),
    .hartRspValid(hVal), .hartRspLast(hLast), .hartRspChan(hChan), .hartRspStatus(hSt),
    .hartRspPv(hPv), .hwFault(hwFault), .mbRegRd(mbRegRd), .mbRegNum(mbRegNum),
    .mbRegData(mbRegData), .mbRegAck(mbRegAck), .mbSlaveAddr(mbSlaveAddr),
    .mbBaudSel(mbBaudSel), .mbParity(mbParity), .relayOn(relayOn),
    .faultLedRed(faultLedRed), .inputLedRed(inputLedRed), .readyLedRed(readyLedRed));
  hmgw_field_model fm (.clock(clock), .srst(srst), .hartReq(hartReq), .hartAddr(hartAddr),
    .mute(mute), .chStatus(chStatus), .hartRspValid(hVal), .hartRspLast(hLast),
    .hartRspChan(hChan), .hartRspStatus(hSt), .hartRspPv(hPv));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic test_done();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ok(input int n);
    if (n >= 2000)
    begin
      n_errors++;
      $display("[FAIL] wait ran out");
      test_done();
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 2000);
    ok(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic mbr(input logic [10:0] num);
    int n;
    mbRegRd <= 1'b1;
    mbRegNum <= num;
    @(posedge clock);
    mbRegRd <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (mbRegAck !== 1'b1 && n < 2000);
    ok(n);
    d = mbRegData;
  endtask
  task automatic t_reset();
    int n;
    chk("slave addr", mbSlaveAddr, 32'h1);
    chk("baud", mbBaudSel, BAUD_9600);
    chk("parity", mbParity, PAR_NONE);
    chk("reset leds", {inputLedRed, readyLedRed, faultLedRed, relayOn}, 32'h0);
    for (n = 0; n < 2000 && hartReq !== 1'b1; n++) @(posedge clock);
    ok(n);
    chk("first poll", hartAddr, 32'h1);
    chk("first poll delay", n, 32'h2);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h50);
    apb(1'b0, OFS_RETRY, 32'h0);
    chk("retry", rd, 32'h3);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
  endtask
  task automatic t_cfg();
    int b, p;
    apb(1'b1, OFS_SLVADDR, 32'hf7);
    apb(1'b1, OFS_SLVADDR, 32'hf8);
    apb(1'b1, OFS_SLVADDR, 32'h0);
    chk("slave max", mbSlaveAddr, 32'hf7);
    for (b = 0; b < 7; b++)
      for (p = 0; p < 3; p++)
      begin
        apb(1'b1, OFS_CTRL, 32'(b * 16 + p * 4));
        chk("baud sel", mbBaudSel, 32'(b));
        chk("parity sel", mbParity, 32'(p));
      end
    apb(1'b1, OFS_CTRL, 32'h70);
    chk("baud 7", mbBaudSel, 32'h6);
    apb(1'b1, OFS_CTRL, 32'h50);
  endtask
  task automatic t_data();
    int n;
    for (n = 0; n < 2000 && !(hLast === 1'b1 && hartAddr === 2'h2); n++) @(posedge clock);
    ok(n);
    repeat (3) @(posedge clock);
    mbr(11'd1);
    chk("reg1 low", d, 32'h0001);
    mbr(11'd2);
    chk("reg2 high", d, 32'h5a00);
    mbr(11'd64);
    chk("reg64", d, 32'h5a0f);
    chk("input led", inputLedRed, 32'h0);
    apb(1'b0, 12'h80c, 32'h0);
    chk("apb pv", rd, 32'h5a03_0001);
    apb(1'b1, OFS_CTRL, 32'h52);
    mbr(11'd33);
    chk("swapped", d, 32'h5a00);
    apb(1'b1, OFS_CTRL, 32'h50);
  endtask
  task automatic t_alarm();
    int n;
    apb(1'b1, OFS_ALM0, 32'h0001_0a02);
    apb(1'b1, OFS_ALM1, 32'h20);
    repeat (2) @(posedge clock);
    chk("healthy relay", relayOn, 32'h1);
    chStatus <= 16'h2002;
    for (n = 0; n < 2000 && !(hLast === 1'b1 && hartAddr === 2'h1); n++) @(posedge clock);
    ok(n);
    repeat (5) @(posedge clock);
    chk("held", {faultLedRed[0], relayOn[0]}, 32'h1);
    for (n = 0; n < 2000 && relayOn[0] !== 1'b0; n++) @(posedge clock);
    ok(n);
    chk("delay", 32'(n >= 55), 32'h1);
    chk("led1", faultLedRed[0], 32'h1);
    for (n = 0; n < 2000 && relayOn[1] !== 1'b1; n++) @(posedge clock);
    ok(n);
    chk("led2", faultLedRed[1], 32'h1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("stat trip", rd[1:0], 32'h3);
    chStatus <= 16'h0000;
    for (n = 0; n < 2000 && relayOn !== 2'h1; n++) @(posedge clock);
    ok(n);
    chk("clear", faultLedRed, 32'h0);
  endtask
  task automatic t_nohart();
    int n;
    apb(1'b1, OFS_RETRY, 32'h1);
    apb(1'b1, OFS_ALM1, 32'h1);
    mute <= 2'h2;
    for (n = 0; n < 2000 && inputLedRed !== 1'b1; n++) @(posedge clock);
    ok(n);
    repeat (3) @(posedge clock);
    chk("nohart relay", {faultLedRed[1], relayOn[1]}, 32'h3);
    mbr(11'd2001);
    chk("gw nohart", d[15], 32'h1);
    apb(1'b1, OFS_CTRL, 32'h51);
    repeat (3) @(posedge clock);
    chk("disabled led", faultLedRed[1], 32'h0);
    repeat (3)
    begin
      for (n = 0; n < 2000 && hartReq !== 1'b1; n++) @(posedge clock);
      ok(n);
      chk("poll addr", hartAddr, 32'h1);
      @(posedge clock);
    end
    hwFault <= 1'b1;
    @(posedge clock);
    hwFault <= 1'b0;
    repeat (3) @(posedge clock);
    chk("ready led", readyLedRed, 32'h1);
    mbr(11'd2001);
    chk("gw hw", d[0], 32'h1);
  endtask
  initial
  begin
    srst = 1'b1;
    {psel, penable, pwrite, hwFault, mbRegRd} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    mbRegNum = 11'h000;
    mute = 2'h0;
    chStatus = 16'h0000;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_cfg();
    t_data();
    t_alarm();
    t_nohart();
    test_done();
  end
endmodule
